// ===== rtl/cpg_top.sv
/*
 Codec path and gain control: control register over APB, analog switch
 decode, and the 14-bit serial transmit/receive port timed by the far
 side's frame sync and bit clock, with an 8-word transmit FIFO.
 Assumes MCLK at 25 MHz, bit clock and sync as asynchronous pins slower
 than MCLK/4, and an APB master that holds each request until pready.
*/
// The implementer's own choices: register access over APB and the address map.
module cpg_top (
   input  wire logic        MCLK,
   input  wire logic        ARST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        FRAME_SYNC,
   input  wire logic        BIT_CLOCK,
   input  wire logic        SERIAL_RX_DATA,
   output logic             SERIAL_TX_DATA,
   output logic             SERIAL_TX_OE,
   output logic             MIC_ON,
   output logic             HANDSET_INPUT_ON,
   output logic             TX_HALF_GAIN,
   output logic             DIFF_OUT_ON,
   output logic             AUX_OUT_ON,
   output logic [4:0]       RX_ATTEN_DB,
   output logic [2:0]       RX_LEVEL
);
   localparam int PB = cpg_pkg::PCM_BITS;

   logic               rst_s1_r;
   logic               rst_n_r;
   logic [1:0]         fs_sync_r;
   logic [1:0]         bc_sync_r;
   logic [1:0]         rx_sync_r;
   logic               fs_d_r;
   logic               bc_d_r;
   logic               fs_rise;
   logic               bc_rise;
   logic               bc_fall;
   cpg_pkg::cpg_ctrl_t ctrl_r;
   cpg_pkg::cpg_ctrl_t ctrl_nxt;
   logic               ctrl_wr;
   logic [3:0]         since_bc_r;
   logic               tx_active_r;
   logic [3:0]         tx_cnt_r;
   logic [PB-1:0]      tx_sh_r;
   logic [3:0]         rx_cnt_r;
   logic [PB-1:0]      rx_sh_r;
   logic [PB-1:0]      rx_word_r;
   logic               rx_new_r;
   logic               underrun_r;
   logic               pat_en_r;
   logic [2:0]         pat_idx_r;
   logic               fifo_in_valid;
   logic               fifo_in_ready;
   logic               fifo_out_valid;
   logic               fifo_pop;
   logic [PB-1:0]      fifo_out_data;
   logic               access;
   logic               status_rd;
   logic               rxdata_rd;
   logic               mapped;
   logic [31:0]        rdata_nxt;
   cpg_pkg::cpg_analog_t ana_nxt;

   // Reset release through two flip-flops
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // Pin synchronisers
   always_ff @(posedge MCLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         fs_sync_r <= '0;
         bc_sync_r <= '0;
         rx_sync_r <= '0;
         fs_d_r    <= 1'b0;
         bc_d_r    <= 1'b0;
      end else begin
         fs_sync_r <= {fs_sync_r[0], FRAME_SYNC};
         bc_sync_r <= {bc_sync_r[0], BIT_CLOCK};
         rx_sync_r <= {rx_sync_r[0], SERIAL_RX_DATA};
         fs_d_r    <= fs_sync_r[1];
         bc_d_r    <= bc_sync_r[1];
      end
   end

   // Edge detectors; the delayed copies reset low like the idle pins, so
   // no false edge follows reset
   assign fs_rise = fs_sync_r[1] && !fs_d_r;
   assign bc_rise = bc_sync_r[1] && !bc_d_r;
   assign bc_fall = !bc_sync_r[1] && bc_d_r;

   // APB decode; the read strobes clear status flags at the access edge
   assign access    = PSEL && PENABLE;
   assign ctrl_wr   = access && PWRITE && (PADDR == cpg_pkg::CTRL_OFS);
   assign status_rd = access && !PWRITE && PREADY && (PADDR == cpg_pkg::STATUS_OFS);
   assign rxdata_rd = access && !PWRITE && PREADY && (PADDR == cpg_pkg::RXDATA_OFS);

   // Address map; anything else answers with an error and no effect
   assign mapped = (PADDR == cpg_pkg::CTRL_OFS) || (PADDR == cpg_pkg::STATUS_OFS)
                || (PADDR == cpg_pkg::TXDATA_OFS) || (PADDR == cpg_pkg::RXDATA_OFS)
                || (PADDR == cpg_pkg::PATTERN_OFS);

   // Next control value from a full bus word
   always_comb begin
      ctrl_nxt          = ctrl_r;
      ctrl_nxt.tx_sel   = cpg_pkg::cpg_tx_sel_t'(PWDATA[cpg_pkg::TX_SEL_LSB +: 2]);
      ctrl_nxt.rx_route = PWDATA[cpg_pkg::RX_ROUTE_LSB +: 2];
      ctrl_nxt.rx_level = PWDATA[cpg_pkg::RX_LEVEL_LSB +: 3];
   end

   // Control register: takes a whole word only at the access edge
   always_ff @(posedge MCLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctrl_r.tx_sel   <= cpg_pkg::CPG_TX_MIC;
         ctrl_r.rx_route <= cpg_pkg::RX_ROUTE_RST;
         ctrl_r.rx_level <= cpg_pkg::RX_LEVEL_RST;
      end else if (ctrl_wr) begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Pattern generator enable
   always_ff @(posedge MCLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pat_en_r <= 1'b0;
      end else if (access && PWRITE && PADDR == cpg_pkg::PATTERN_OFS) begin
         pat_en_r <= PWDATA[0];
      end
   end

   // Read mux
   always_comb begin
      rdata_nxt = '0;
      unique case (PADDR)
         cpg_pkg::CTRL_OFS: begin
            rdata_nxt[cpg_pkg::TX_SEL_LSB +: 2]   = ctrl_r.tx_sel;
            rdata_nxt[cpg_pkg::RX_ROUTE_LSB +: 2] = ctrl_r.rx_route;
            rdata_nxt[cpg_pkg::RX_LEVEL_LSB +: 3] = ctrl_r.rx_level;
         end
         cpg_pkg::STATUS_OFS: begin
            rdata_nxt[0] = fifo_out_valid;
            rdata_nxt[1] = !fifo_in_ready;
            rdata_nxt[2] = rx_new_r;
            rdata_nxt[3] = underrun_r;
            rdata_nxt[4] = tx_active_r;
         end
         cpg_pkg::RXDATA_OFS: rdata_nxt[PB-1:0] = rx_word_r;
         cpg_pkg::PATTERN_OFS: rdata_nxt[0] = pat_en_r;
         default: rdata_nxt = '0;
      endcase
   end

   // Bus answer: zero-wait, error on unmapped address
   always_ff @(posedge MCLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         PRDATA  <= '0;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? rdata_nxt : '0;
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !mapped;
      end
   end

   // Transmit words enter the FIFO; a write to a full FIFO is dropped, so
   // software checks the full bit before it writes
   assign fifo_in_valid = access && PWRITE && PADDR == cpg_pkg::TXDATA_OFS && PREADY;

   cpg_fifo #(
      .WIDTH (PB),
      .DEPTH (cpg_pkg::FIFO_DEPTH)
   ) u_tx_fifo (
      .clk       (MCLK),
      .rst_n     (rst_n_r),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (PWDATA[PB-1:0]),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   // Cycles since the last bit clock rise, saturating; held against half a
   // bit period when sync arrives to pick the launch of the first bit
   always_ff @(posedge MCLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         since_bc_r <= '1;
      end else if (bc_rise) begin
         since_bc_r <= '0;
      end else if (since_bc_r != '1) begin
         since_bc_r <= since_bc_r + 1'b1;
      end
   end

   // Word is taken at sync rise from the pattern or the FIFO
   assign fifo_pop = fs_rise && !pat_en_r && fifo_out_valid;

   // Transmit shifter: the first bit goes out on sync rise if sync came
   // late in the bit (within half a period of the next edge), else on the
   // next bit clock rise; later bits follow each bit clock rise
   always_ff @(posedge MCLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tx_active_r    <= 1'b0;
         tx_cnt_r       <= '0;
         tx_sh_r        <= '0;
         SERIAL_TX_DATA <= 1'b1;
         SERIAL_TX_OE   <= 1'b0;
         pat_idx_r      <= '0;
      end else begin
         if (fs_rise) begin
            tx_active_r <= 1'b1;
            if (pat_en_r) begin
               tx_sh_r   <= cpg_pkg::PATTERN[pat_idx_r];
               pat_idx_r <= pat_idx_r + 1'b1;
            end else if (fifo_out_valid) begin
               tx_sh_r <= fifo_out_data;
            end else begin
               tx_sh_r <= '0; // Nothing queued: send a zero word
            end
            if (since_bc_r >= cpg_pkg::HALF_BIT_CNT && !bc_rise) begin
               tx_cnt_r <= 4'(PB);
            end else begin
               tx_cnt_r <= 4'(PB + 1);
            end
         end else if (tx_active_r && tx_cnt_r == 4'(PB)) begin
            SERIAL_TX_DATA <= tx_sh_r[PB-1];
            SERIAL_TX_OE   <= 1'b1;
            tx_sh_r        <= {tx_sh_r[PB-2:0], 1'b0};
            tx_cnt_r       <= tx_cnt_r - 1'b1;
         end else if (tx_active_r && bc_rise) begin
            if (tx_cnt_r == '0) begin
               tx_active_r    <= 1'b0;
               SERIAL_TX_OE   <= 1'b0;
               SERIAL_TX_DATA <= 1'b1;
            end else begin
               SERIAL_TX_DATA <= tx_sh_r[PB-1];
               SERIAL_TX_OE   <= 1'b1;
               tx_sh_r        <= {tx_sh_r[PB-2:0], 1'b0};
               tx_cnt_r       <= (tx_cnt_r == 4'(PB + 1)) ? 4'(PB - 1) : tx_cnt_r - 1'b1;
            end
         end
      end
   end

   // Underrun flag: a sync with nothing to send sets it and a status read
   // clears it; the set wins when both land in one cycle, so an underrun
   // is kept if it lands in a read's access cycle, but cleared unread if it lands in its setup cycle
   always_ff @(posedge MCLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         underrun_r <= 1'b0;
      end else if (fs_rise && !pat_en_r && !fifo_out_valid) begin
         underrun_r <= 1'b1;
      end else if (status_rd) begin
         underrun_r <= 1'b0;
      end
   end

   // Receive shifter: MSB first on bit clock falls after sync
   always_ff @(posedge MCLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rx_cnt_r  <= '0;
         rx_sh_r   <= '0;
         rx_word_r <= '0;
      end else begin
         if (fs_rise) begin
            rx_cnt_r <= 4'(PB);
         end else if (bc_fall && rx_cnt_r != '0) begin
            rx_sh_r  <= {rx_sh_r[PB-2:0], rx_sync_r[1]};
            rx_cnt_r <= rx_cnt_r - 1'b1;
            if (rx_cnt_r == 4'h1) begin
               rx_word_r <= {rx_sh_r[PB-2:0], rx_sync_r[1]};
            end
         end
      end
   end

   // New-word flag: set as the last bit lands, cleared by a data read;
   // the set wins, so a word that completes in the read's access cycle stays flagged, but not one in its setup cycle
   always_ff @(posedge MCLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rx_new_r <= 1'b0;
      end else if (!fs_rise && bc_fall && rx_cnt_r == 4'h1) begin
         rx_new_r <= 1'b1;
      end else if (rxdata_rd) begin
         rx_new_r <= 1'b0;
      end
   end

   // Analog switch decode
   always_comb begin
      ana_nxt.mic_on    = ctrl_r.tx_sel[0];
      ana_nxt.hset_on   = ctrl_r.tx_sel[1];
      ana_nxt.half_gain = (ctrl_r.tx_sel == cpg_pkg::CPG_TX_SUM);
      ana_nxt.diff_on   = ctrl_r.rx_route[0];
      ana_nxt.aux_on    = ctrl_r.rx_route[1];
      ana_nxt.atten_db  = 5'({2'h0, ctrl_r.rx_level} * 5'(cpg_pkg::LEVEL_STEP_DB));
   end

   // Registered transmit input switches
   always_ff @(posedge MCLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         MIC_ON           <= 1'b1;
         HANDSET_INPUT_ON <= 1'b0;
         TX_HALF_GAIN     <= 1'b0;
      end else begin
         MIC_ON           <= ana_nxt.mic_on;
         HANDSET_INPUT_ON <= ana_nxt.hset_on;
         TX_HALF_GAIN     <= ana_nxt.half_gain;
      end
   end

   // Registered receive routing and gain; attenuation and code move together
   always_ff @(posedge MCLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         DIFF_OUT_ON      <= 1'b1;
         AUX_OUT_ON       <= 1'b0;
         RX_ATTEN_DB      <= '0;
         RX_LEVEL         <= cpg_pkg::RX_LEVEL_RST;
      end else begin
         DIFF_OUT_ON      <= ana_nxt.diff_on;
         AUX_OUT_ON       <= ana_nxt.aux_on;
         RX_ATTEN_DB      <= ana_nxt.atten_db;
         RX_LEVEL         <= ctrl_r.rx_level;
      end
   end
endmodule

// ===== rtl/cpg_pkg.sv
/*
 Shared constants and carriers for the codec path and gain control block.
 Assumes a single 25 MHz system clock and an APB master for the registers.
*/
package cpg_pkg;
   // Register byte addresses
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] STATUS_OFS  = 8'h04;
   localparam logic [7:0] TXDATA_OFS  = 8'h08;
   localparam logic [7:0] RXDATA_OFS  = 8'h0c;
   localparam logic [7:0] PATTERN_OFS = 8'h10;
   // Control field positions
   localparam int TX_SEL_LSB   = 0;
   localparam int RX_ROUTE_LSB = 2;
   localparam int RX_LEVEL_LSB = 4;
   // Values after reset
   localparam logic [1:0] TX_SEL_RST   = 2'h1;
   localparam logic [1:0] RX_ROUTE_RST = 2'h1;
   localparam logic [2:0] RX_LEVEL_RST = 3'h0;
   // Serial word, buffering and gain steps
   localparam int PCM_BITS    = 14;
   localparam int FIFO_DEPTH  = 8;
   localparam int PATTERN_LEN = 8;
   localparam int LEVEL_STEP_DB = 4;
   localparam int SUM_CUT_DB    = 6;
   // Half a bit-clock period at 320 ns with a 40 ns clock
   localparam int CLK_NS        = 40;
   localparam int BCLK_NS       = 320;
   localparam int HALF_BIT_CYC  = (BCLK_NS / 2) / CLK_NS;
   localparam logic [3:0] HALF_BIT_CNT = 4'(HALF_BIT_CYC);

   typedef enum logic [1:0] {
      CPG_TX_MUTE = 2'h0,
      CPG_TX_MIC  = 2'h1,
      CPG_TX_HSET = 2'h2,
      CPG_TX_SUM  = 2'h3
   } cpg_tx_sel_t;

   typedef struct packed {
      logic [2:0]  rx_level;
      logic [1:0]  rx_route;
      cpg_tx_sel_t tx_sel;
   } cpg_ctrl_t;

   typedef struct packed {
      logic        mic_on;
      logic        hset_on;
      logic        half_gain;
      logic        diff_on;
      logic        aux_on;
      logic [4:0]  atten_db;
   } cpg_analog_t;

   // Reference 0 dBm0 tone codes, sample 1 first
   typedef logic [PCM_BITS-1:0] cpg_pcm_t;
   localparam cpg_pcm_t PATTERN [PATTERN_LEN] = '{
      14'h08ab, 14'h14ee, 14'h14ee, 14'h08ab,
      14'h3754, 14'h2b11, 14'h2b11, 14'h3754};
endpackage

// ===== rtl/cpg_fifo.sv
/*
 Parameterised valid/ready FIFO.
 Assumes one clock and a synchronous-release active-low reset.
*/
module cpg_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   // Handshake terms
   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rp_r];

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ===== testbench/cpg_dsp_model.sv
/*
 Far-side controller model: frame sync, bit clock, receive data; captures words.
 Assumes the bench calls frame(); the bit clock stands still low between frames.
*/
module cpg_dsp_model (
   output logic      sync,
   output logic      bclk,
   output logic      rx_data,
   input  wire logic tx_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [13:0] rxw_r;
   logic [13:0] txw_r;
   int          r;
   int          t;
   // Pins start low
   initial begin
      sync = 1'b0;
      bclk = 1'b0;
      rx_data = 1'b0;
   end
   // One 320 ns period; transmit bit taken late in the low phase, where it is settled
   task automatic period(input bit smp, input bit rs);
      bclk = 1'b1;
      #20 rx_data = (r >= 0) ? rxw_r[r] : ~rx_data;
      #20 sync = sync | rs;
      #120 bclk = 1'b0;
      #150 if (smp && t >= 0) begin
         txw_r[t] = tx_data;
         t--;
      end
      if (r >= 0) r--;
      #10;
   endtask
   // One frame: first bit timed from sync (st) or from the bit clock
   task automatic frame(input bit st, input logic [13:0] rxw);
      #7 rxw_r = rxw;
      r = 13;
      t = 13;
      if (st) begin
         sync = 1'b1;
         #400 txw_r[13] = tx_data;
         t = 12;
         #80;
      end else begin
         period(1'b0, 1'b1);
      end
      for (int k = 0; k < 14; k++) begin
         period(1'b1, 1'b0);
         sync = 1'b0;
      end
      bclk = 1'b1;
      #160 bclk = 1'b0;
   endtask
endmodule

// ===== testbench/cpg_checker.sv
/*
 Port checks for the codec path and gain control block.
 Assumes it is bound to cpg_top and sees only its ports.
*/
module cpg_checker (
   input wire logic        MCLK,
   input wire logic        ARST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic        FRAME_SYNC,
   input wire logic        BIT_CLOCK,
   input wire logic        SERIAL_TX_OE,
   input wire logic        MIC_ON,
   input wire logic        HANDSET_INPUT_ON,
   input wire logic        TX_HALF_GAIN,
   input wire logic        DIFF_OUT_ON,
   input wire logic        AUX_OUT_ON,
   input wire logic [4:0]  RX_ATTEN_DB,
   input wire logic [2:0]  RX_LEVEL
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        wr_ctrl;
   logic [12:0] outs;
   logic [6:0]  wd_r;
   logic        bq_r;
   logic [3:0]  ic_r;
   logic [4:0]  nb_r;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   // Completed control write and the output group
   assign wr_ctrl = PSEL && PENABLE && PREADY && PWRITE && PADDR == cpg_pkg::CTRL_OFS;
   assign outs = {MIC_ON, HANDSET_INPUT_ON, TX_HALF_GAIN, DIFF_OUT_ON, AUX_OUT_ON,
                  RX_ATTEN_DB, RX_LEVEL};
   // Last control word, idle count and bit count of the bit clock
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wd_r <= 7'h00;
         bq_r <= 1'b0;
         ic_r <= 4'h0;
         nb_r <= 5'h00;
      end else begin
         bq_r <= BIT_CLOCK;
         if (wr_ctrl) wd_r <= PWDATA[6:0];
         if (BIT_CLOCK && !bq_r) ic_r <= 4'h0;
         else if (ic_r != 4'hf) ic_r <= ic_r + 4'h1;
         if (!SERIAL_TX_OE) nb_r <= 5'h00;
         else if (BIT_CLOCK && !bq_r) nb_r <= nb_r + 5'h01;
      end
   end
   // Sync after a quiet bit clock of half a period or more, not on a rise
   sequence sync_idle_s;
      $rose(FRAME_SYNC) && ic_r >= cpg_pkg::HALF_BIT_CNT && !(BIT_CLOCK && !bq_r);
   endsequence
   sequence launch_s;
      ##[2:7] $rose(SERIAL_TX_OE);
   endsequence
   ctrl_hold_a: assert property (
      !$stable(outs) |-> $past(wr_ctrl) || $past(wr_ctrl, 2)) else $error("Outputs moved");
   tx_decode_a: assert property (
      wr_ctrl |-> ##2 {HANDSET_INPUT_ON, MIC_ON} == wd_r[1:0]) else $error("Tx select");
   sum_cut_a: assert property (
      TX_HALF_GAIN == (MIC_ON && HANDSET_INPUT_ON)) else $error("Sum gain cut");
   route_decode_a: assert property (
      wr_ctrl |-> ##2 {AUX_OUT_ON, DIFF_OUT_ON} == wd_r[3:2]) else $error("Rx route");
   level_load_a: assert property (
      wr_ctrl |-> ##2 RX_LEVEL == wd_r[6:4]) else $error("Rx level");
   atten_step_a: assert property (
      RX_ATTEN_DB == {RX_LEVEL, 2'b00}) else $error("Attenuation step");
   first_bit_a: assert property (
      sync_idle_s |-> launch_s) else $error("First bit not from sync");
   word_len_a: assert property (
      $fell(SERIAL_TX_OE) |-> nb_r == 5'd14) else $error("Word length");
endmodule

// ===== testbench/tb_cpg_top.sv
/*
 Self-checking bench for cpg_top: registers over APB, frames via the far-side model.
 Assumes cpg_dsp_model and cpg_checker are compiled first.
*/
module tb_cpg_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        MCLK = 1'b0;
   logic        ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, PRDATA;
   logic        FRAME_SYNC, BIT_CLOCK, SERIAL_RX_DATA, SERIAL_TX_DATA, SERIAL_TX_OE;
   logic        MIC_ON, HANDSET_INPUT_ON, TX_HALF_GAIN, DIFF_OUT_ON, AUX_OUT_ON;
   logic [4:0]  RX_ATTEN_DB;
   logic [2:0]  RX_LEVEL;
   logic [12:0] outs;
   int          fails = 0;
   int          n_tests = 0;
   // Output group and 40 ns clock
   assign outs = {MIC_ON, HANDSET_INPUT_ON, TX_HALF_GAIN, DIFF_OUT_ON, AUX_OUT_ON,
                  RX_ATTEN_DB, RX_LEVEL};
   always #20 MCLK = ~MCLK;
   cpg_top dut (.MCLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
      .PREADY, .PSLVERR, .FRAME_SYNC, .BIT_CLOCK, .SERIAL_RX_DATA, .SERIAL_TX_DATA,
      .SERIAL_TX_OE, .MIC_ON, .HANDSET_INPUT_ON, .TX_HALF_GAIN, .DIFF_OUT_ON,
      .AUX_OUT_ON, .RX_ATTEN_DB, .RX_LEVEL);
   cpg_dsp_model dsp (.sync(FRAME_SYNC), .bclk(BIT_CLOCK), .rx_data(SERIAL_RX_DATA),
      .tx_data(SERIAL_TX_DATA));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("Compares %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // One APB transfer; the request stands until pready is sampled high at a
   // rising edge, where read data and the error flag are taken
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   // One frame; time from sync rise to drive enable, then the received word
   task automatic run_frame(input bit st, input logic [13:0] rxw, output logic [13:0] txw);
      int          n;
      logic [31:0] q;
      n = 0;
      fork
         dsp.frame(st, rxw);
         begin
            @(posedge FRAME_SYNC);
            while (SERIAL_TX_OE !== 1'b1 && n < 40) begin
               @(posedge MCLK);
               n++;
            end
         end
      join
      txw = dsp.txw_r;
      chk(32'(st ? n < 8 : n > 8), 32'h1);
      @(posedge MCLK);
      rd(cpg_pkg::RXDATA_OFS, q);
      chk(q, 32'(rxw));
   endtask
   // Reset values, unmapped address
   task automatic t_reset;
      logic [31:0] q;
      logic        e;
      chk(32'(outs), 32'h1200);
      rd(cpg_pkg::CTRL_OFS, q);
      chk(q, 32'h5);
      apb(1'b0, 8'h14, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      $display("Reset test done");
   endtask
   // Every control code
   task automatic t_ctrl;
      logic [31:0] q;
      logic [6:0]  c;
      for (int k = 0; k < 128; k++) begin
         c = 7'(k);
         wr(cpg_pkg::CTRL_OFS, {25'h0, c});
         rd(cpg_pkg::CTRL_OFS, q);
         chk(q, {25'h0, c});
         chk(32'(outs),
             {19'h0, c[0], c[1], &c[1:0], c[2], c[3], c[6:4], 2'h0, c[6:4]});
      end
      wr(cpg_pkg::CTRL_OFS, 32'h5);
      $display("Control test done");
   endtask
   // Reference tone over both first-bit timings
   task automatic t_pattern;
      logic [13:0] s [8];
      wr(cpg_pkg::PATTERN_OFS, 32'h1);
      for (int k = 0; k < 8; k++) begin
         run_frame(k[0], 14'(k * 1234 + 99), s[k]);
         chk(32'(s[k]), 32'(cpg_pkg::PATTERN[k]));
         if (k >= 4) chk(32'(s[k] ^ s[k - 4]), 32'h3fff);
      end
      wr(cpg_pkg::PATTERN_OFS, 32'h0);
      $display("Pattern test done");
   endtask
   // Fill the buffer past full, drain it, one frame short of data
   task automatic t_fifo;
      logic [31:0] q;
      logic [13:0] w;
      logic [13:0] x;
      for (int k = 0; k < 9; k++) wr(cpg_pkg::TXDATA_OFS, 32'h3a5c ^ (k * 32'h123));
      rd(cpg_pkg::STATUS_OFS, q);
      chk(q & 32'h3, 32'h3);
      for (int k = 0; k < 9; k++) begin
         w = (k < 8) ? 14'(32'h3a5c ^ (k * 32'h123)) : 14'h0;
         run_frame(k[1], ~w, x);
         chk(32'(x), 32'(w));
      end
      rd(cpg_pkg::STATUS_OFS, q);
      chk(q & 32'h9, 32'h8);
      rd(cpg_pkg::STATUS_OFS, q);
      chk(q & 32'h8, 32'h0);
      $display("Buffer test done");
   endtask
   // Main sequence
   initial begin
      ARST_N = 1'b0;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      repeat (16) @(posedge MCLK);
      ARST_N <= 1'b1;
      repeat (3) @(posedge MCLK);
      t_reset;
      t_ctrl;
      t_pattern;
      t_fifo;
      tally_and_finish;
   end
   // Watchdog
   initial begin
      #1000000;
      fails++;
      tally_and_finish;
   end
endmodule
bind cpg_top cpg_checker chk_i (.MCLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
   .PWDATA, .PREADY, .FRAME_SYNC, .BIT_CLOCK, .SERIAL_TX_OE, .MIC_ON, .HANDSET_INPUT_ON,
   .TX_HALF_GAIN, .DIFF_OUT_ON, .AUX_OUT_ON, .RX_ATTEN_DB, .RX_LEVEL);
